// ---- rtl/lvt_core.sv ----
`timescale 1ns/1ps
// Contract
// - seven 32-bit entries, one per source
// - decode delivery type fixed/smi/nmi/init/external
// - nmi delivery ignores the vector field
// - external mode routes acknowledge to external controller
// - status bit set until core accepts
// - polarity bit selects active high or low
// - acceptance flag set on accept of a level fixed pin, cleared by eoi
// - pin trigger bit selects edge or level
// - forced edge or level by delivery type
// - no io controller forces level for fixed
// - mask bit blocks reception of the source
// - perf interrupt handling sets its mask bit
// - timer mode bit one-shot or periodic
// - vectors 16 to 255 are legal
// - illegal vector sets error status bit
// - illegal fixed vector write flags error
// - thermal at 0330h, perf at own address
// - error status set raises error entry interrupt
// - illegal received vector never delivered
module lvt_core (
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [31:0] i_reg_addr,
   input  wire logic [31:0] i_reg_wdata,
   output logic      [31:0] o_reg_rdata,
   input  wire logic        i_timer_evt,
   input  wire logic        i_thermal_evt,
   input  wire logic        i_perf_evt,
   input  wire logic        i_corr_err_evt,
   input  wire logic        i_local_irq_pin0,
   input  wire logic        i_local_irq_pin1,
   input  wire logic        i_no_io_ctrl,
   output logic             o_irq_valid,
   output logic      [2:0]  o_irq_type,
   output logic      [7:0]  o_irq_vector,
   output logic      [2:0]  o_irq_src,
   output logic             o_intack_route,
   input  wire logic        i_irq_accept,
   input  wire logic        i_eoi,
   input  wire logic [7:0]  i_eoi_vector,
   output logic             o_timer_periodic,
   output logic             o_err_recv_illegal,
   input  wire logic        i_err_clr
);
   localparam int N = lvt_pkg::NSRC;

   logic [31:0] entry_r [N];
   logic [N-1:0] pend_r;
   logic [N-1:0] racc_r;
   logic         cur_valid_r;
   logic [2:0]   cur_src_r;
   logic [2:0]   cur_type_r;
   logic [7:0]   cur_vec_r;
   logic [31:0]  reg_rdata_r;
   logic         recv_illegal_r;
   logic         recv_prev_r;

   logic         hit;
   logic [2:0]   hit_idx;
   logic         wr_hit;
   logic [31:0]  wr_val;
   logic         wr_illegal;
   logic         pin_lvl0, pin_lvl1, pin_rise0, pin_rise1;
   logic [N-1:0] evt;
   logic [N-1:0] lvl_src;
   logic [N-1:0] eff_level;
   logic [N-1:0] eligible;
   logic [N-1:0] illegal_rx;
   logic [N-1:0] pend_set;
   logic         err_evt;
   logic         recv_set;
   logic         accept;
   logic         sel_any;
   logic [2:0]   sel_idx;

   // ==========================================================
   // field helpers
   function automatic logic [2:0] mode_of(input logic [31:0] e);
      mode_of = e[lvt_pkg::MODE_LSB +: lvt_pkg::MODE_W];
   endfunction : mode_of

   function automatic logic [7:0] vec_of(input logic [31:0] e);
      vec_of = e[lvt_pkg::VEC_LSB +: lvt_pkg::VEC_W];
   endfunction : vec_of

   function automatic logic vec_illegal(input logic [7:0] v);
      vec_illegal = (v < lvt_pkg::VEC_MIN_LEGAL);
   endfunction : vec_illegal

   function automatic logic mode_known(input logic [2:0] m);
      case (m)
         lvt_pkg::MODE_FIXED, lvt_pkg::MODE_SMI, lvt_pkg::MODE_NMI,
         lvt_pkg::MODE_INIT, lvt_pkg::MODE_EXT: mode_known = 1'b1;
         default:                               mode_known = 1'b0;
      endcase
   endfunction : mode_known

   // ==========================================================
   // address decode
   always_comb begin
      hit     = 1'b1;
      hit_idx = lvt_pkg::IDX_TIMER;
      case (i_reg_addr)
         lvt_pkg::ADDR_TIMER:   hit_idx = lvt_pkg::IDX_TIMER;
         lvt_pkg::ADDR_THERMAL: hit_idx = lvt_pkg::IDX_THERMAL;
         lvt_pkg::ADDR_PERF:    hit_idx = lvt_pkg::IDX_PERF;
         lvt_pkg::ADDR_PIN0:    hit_idx = lvt_pkg::IDX_PIN0;
         lvt_pkg::ADDR_PIN1:    hit_idx = lvt_pkg::IDX_PIN1;
         lvt_pkg::ADDR_ERROR:   hit_idx = lvt_pkg::IDX_ERROR;
         lvt_pkg::ADDR_CORR:    hit_idx = lvt_pkg::IDX_CORR;
         default:               hit = 1'b0;
      endcase
   end

   assign wr_hit     = i_reg_wr & hit;
   assign wr_val     = i_reg_wdata & lvt_pkg::wmask_of(hit_idx);
   assign wr_illegal = wr_hit & (mode_of(wr_val) == lvt_pkg::MODE_FIXED)
                       & vec_illegal(vec_of(wr_val));

   // ==========================================================
   // pin conditioning
   lvt_pin_cond u_pin0 (
      .i_clk        (i_clk),
      .i_sys_rst    (i_sys_rst),
      .i_pin        (i_local_irq_pin0),
      .i_active_low (entry_r[lvt_pkg::IDX_PIN0][lvt_pkg::POL_BIT]),
      .o_level      (pin_lvl0),
      .o_rise       (pin_rise0)
   );

   lvt_pin_cond u_pin1 (
      .i_clk        (i_clk),
      .i_sys_rst    (i_sys_rst),
      .i_pin        (i_local_irq_pin1),
      .i_active_low (entry_r[lvt_pkg::IDX_PIN1][lvt_pkg::POL_BIT]),
      .o_level      (pin_lvl1),
      .o_rise       (pin_rise1)
   );

   // ==========================================================
   // trigger sense and reception
   // taken from the registered flag: the error entry can itself flag an illegal vector
   assign err_evt = recv_illegal_r & ~recv_prev_r;

   always_comb begin
      evt     = '0;
      lvl_src = '0;
      evt[lvt_pkg::IDX_TIMER]     = i_timer_evt;
      evt[lvt_pkg::IDX_THERMAL]   = i_thermal_evt;
      evt[lvt_pkg::IDX_PERF]      = i_perf_evt;
      evt[lvt_pkg::IDX_PIN0]      = pin_rise0;
      evt[lvt_pkg::IDX_PIN1]      = pin_rise1;
      evt[lvt_pkg::IDX_ERROR]     = err_evt;
      evt[lvt_pkg::IDX_CORR]      = i_corr_err_evt;
      lvl_src[lvt_pkg::IDX_PIN0]  = pin_lvl0;
      lvl_src[lvt_pkg::IDX_PIN1]  = pin_lvl1;
   end

   // only the pins can be level sensed; timer and error stay edge
   always_comb begin
      eff_level = '0;
      for (int i = 0; i < N; i++) begin
         if (i == lvt_pkg::IDX_PIN0 || i == lvt_pkg::IDX_PIN1) begin
            case (mode_of(entry_r[i]))
               lvt_pkg::MODE_EXT:   eff_level[i] = 1'b1;
               lvt_pkg::MODE_FIXED: eff_level[i] =
                  entry_r[i][lvt_pkg::TRIG_BIT] | i_no_io_ctrl;
               default:             eff_level[i] = 1'b0;
            endcase
         end
      end
   end

   always_comb begin
      for (int i = 0; i < N; i++) begin
         eligible[i] = (eff_level[i] ? lvl_src[i] : evt[i])
                       & ~entry_r[i][lvt_pkg::MASK_BIT]
                       & ~pend_r[i]
                       & ~(eff_level[i] & racc_r[i])
                       & mode_known(mode_of(entry_r[i]));
         illegal_rx[i] = eligible[i]
                         & (mode_of(entry_r[i]) == lvt_pkg::MODE_FIXED)
                         & vec_illegal(vec_of(entry_r[i]));
         pend_set[i] = eligible[i] & ~illegal_rx[i];
      end
   end

   assign recv_set = (|illegal_rx) | wr_illegal;

   // ==========================================================
   // entry registers
   // a hardware mask set beats a same-cycle software clear
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         for (int i = 0; i < N; i++) entry_r[i] <= lvt_pkg::ENTRY_RESET;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (wr_hit && hit_idx == 3'(i)) entry_r[i] <= wr_val;
         end
         if (accept && cur_src_r == lvt_pkg::IDX_PERF)
            entry_r[lvt_pkg::IDX_PERF][lvt_pkg::MASK_BIT] <= 1'b1;
      end
   end

   assign o_timer_periodic = entry_r[lvt_pkg::IDX_TIMER][lvt_pkg::TMODE_BIT];

   // ==========================================================
   // delivery status and selection
   assign accept = cur_valid_r & i_irq_accept;

   always_comb begin
      sel_any = 1'b0;
      sel_idx = 3'h0;
      for (int i = N - 1; i >= 0; i--) begin
         if (pend_r[i]) begin
            sel_any = 1'b1;
            sel_idx = 3'(i);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pend_r <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (pend_set[i])                          pend_r[i] <= 1'b1;
            else if (accept && cur_src_r == 3'(i))    pend_r[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cur_valid_r <= 1'b0;
         cur_src_r   <= 3'h0;
         cur_type_r  <= 3'h0;
         cur_vec_r   <= 8'h00;
      end else if (accept) begin
         cur_valid_r <= 1'b0;
      end else if (!cur_valid_r && sel_any) begin
         cur_valid_r <= 1'b1;
         cur_src_r   <= sel_idx;
         cur_type_r  <= mode_of(entry_r[sel_idx]);
         // only fixed delivery carries the programmed vector
         cur_vec_r   <= (mode_of(entry_r[sel_idx]) == lvt_pkg::MODE_FIXED)
                        ? vec_of(entry_r[sel_idx]) : 8'h00;
      end
   end

   assign o_irq_valid    = cur_valid_r;
   assign o_irq_src      = cur_src_r;
   assign o_irq_type     = cur_type_r;
   assign o_irq_vector   = cur_vec_r;
   assign o_intack_route = cur_valid_r & (cur_type_r == lvt_pkg::MODE_EXT);

   // ==========================================================
   // remote acceptance, level fixed pins only
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         racc_r <= '0;
      end else begin
         for (int i = 0; i < N; i++) begin
            if (accept && cur_src_r == 3'(i) && eff_level[i]
                && cur_type_r == lvt_pkg::MODE_FIXED)
               racc_r[i] <= 1'b1;
            else if (i_eoi && i_eoi_vector == vec_of(entry_r[i]))
               racc_r[i] <= 1'b0;
         end
      end
   end

   // ==========================================================
   // error status, set wins over clear
   always_ff @(posedge i_clk) begin
      if (i_sys_rst)     recv_illegal_r <= 1'b0;
      else if (recv_set) recv_illegal_r <= 1'b1;
      else if (i_err_clr) recv_illegal_r <= 1'b0;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) recv_prev_r <= 1'b0;
      else           recv_prev_r <= recv_illegal_r;
   end

   assign o_err_recv_illegal = recv_illegal_r;

   // ==========================================================
   // read path, one cycle latency
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         reg_rdata_r <= 32'h0000_0000;
      end else if (i_reg_rd) begin
         if (hit)
            reg_rdata_r <= (entry_r[hit_idx] & lvt_pkg::wmask_of(hit_idx))
                           | (32'(pend_r[hit_idx]) << lvt_pkg::STAT_BIT)
                           | (32'(racc_r[hit_idx]) << lvt_pkg::RACC_BIT);
         else
            reg_rdata_r <= 32'h0000_0000;
      end
   end

   assign o_reg_rdata = reg_rdata_r;

   // ==========================================================
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   a_mask_blocks_set: assert property (
      entry_r[lvt_pkg::IDX_TIMER][lvt_pkg::MASK_BIT] && i_timer_evt
      && !pend_r[lvt_pkg::IDX_TIMER] |=> !pend_r[lvt_pkg::IDX_TIMER])
      else $error("masked timer event became pending");

   a_status_holds: assert property (
      cur_valid_r && !i_irq_accept |=> pend_r[cur_src_r] && cur_valid_r)
      else $error("status dropped before acceptance");

   a_accept_clears: assert property (
      accept && !pend_set[cur_src_r] |=> !pend_r[$past(cur_src_r)])
      else $error("status not cleared after acceptance");

   a_nmi_no_vector: assert property (
      cur_valid_r && cur_type_r != lvt_pkg::MODE_FIXED |-> cur_vec_r == 8'h00)
      else $error("vector carried on non-fixed delivery");

   a_fixed_vec_legal: assert property (
      cur_valid_r && cur_type_r == lvt_pkg::MODE_FIXED |-> !vec_illegal(cur_vec_r))
      else $error("illegal vector delivered");

   a_illegal_flags: assert property (
      |illegal_rx |=> recv_illegal_r)
      else $error("illegal receive not recorded");

   a_write_illegal: assert property (
      wr_illegal ##1 1'b1 |-> recv_illegal_r)
      else $error("illegal fixed write not recorded");

   a_perf_mask_set: assert property (
      accept && cur_src_r == lvt_pkg::IDX_PERF
      |=> entry_r[lvt_pkg::IDX_PERF][lvt_pkg::MASK_BIT] [*2])
      else $error("perf mask not set after handling");

   a_err_raises: assert property (
      err_evt && !entry_r[lvt_pkg::IDX_ERROR][lvt_pkg::MASK_BIT]
      && !vec_illegal(vec_of(entry_r[lvt_pkg::IDX_ERROR]))
      && !pend_r[lvt_pkg::IDX_ERROR] |=> pend_r[lvt_pkg::IDX_ERROR])
      else $error("error status set without error interrupt");

   a_ext_route: assert property (
      o_intack_route |-> o_irq_valid && o_irq_type == lvt_pkg::MODE_EXT)
      else $error("acknowledge routed outside external mode");

   a_nmi_edge: assert property (
      mode_of(entry_r[lvt_pkg::IDX_PIN0]) == lvt_pkg::MODE_NMI
      |-> !eff_level[lvt_pkg::IDX_PIN0])
      else $error("nmi pin not edge sensed");

   a_no_ioc_level: assert property (
      i_no_io_ctrl && mode_of(entry_r[lvt_pkg::IDX_PIN1]) == lvt_pkg::MODE_FIXED
      |-> eff_level[lvt_pkg::IDX_PIN1])
      else $error("fixed pin not level sensed without io controller");
endmodule : lvt_core

// ---- rtl/lvt_pin_cond.sv ----
`timescale 1ns/1ps
module lvt_pin_cond (
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   input  wire logic i_pin,
   input  wire logic i_active_low,
   output logic      o_level,
   output logic      o_rise
);
   logic sync1_r;
   logic sync2_r;
   logic prev_r;

   // ==========================================================
   // two-flop synchroniser, then polarity and edge
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= i_pin;
         sync2_r <= sync1_r;
      end
   end

   assign o_level = sync2_r ^ i_active_low;

   // a polarity flip can look like an edge; software should mask first
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) prev_r <= 1'b0;
      else           prev_r <= o_level;
   end

   assign o_rise = o_level & ~prev_r;
endmodule : lvt_pin_cond

// ---- rtl/lvt_pkg.sv ----
package lvt_pkg;
   // ==========================================================
   // source indices
   localparam int         NSRC        = 7;
   localparam logic [2:0] IDX_TIMER   = 3'h0;
   localparam logic [2:0] IDX_THERMAL = 3'h1;
   localparam logic [2:0] IDX_PERF    = 3'h2;
   localparam logic [2:0] IDX_PIN0    = 3'h3;
   localparam logic [2:0] IDX_PIN1    = 3'h4;
   localparam logic [2:0] IDX_ERROR   = 3'h5;
   localparam logic [2:0] IDX_CORR    = 3'h6;

   // ==========================================================
   // entry addresses
   localparam logic [31:0] ADDR_CORR    = 32'hfee0_02f0;
   localparam logic [31:0] ADDR_TIMER   = 32'hfee0_0320;
   localparam logic [31:0] ADDR_THERMAL = 32'hfee0_0330;
   localparam logic [31:0] ADDR_PERF    = 32'hfee0_0340;
   localparam logic [31:0] ADDR_PIN0    = 32'hfee0_0350;
   localparam logic [31:0] ADDR_PIN1    = 32'hfee0_0360;
   localparam logic [31:0] ADDR_ERROR   = 32'hfee0_0370;

   // ==========================================================
   // entry fields
   localparam int VEC_LSB   = 0;
   localparam int VEC_W     = 8;
   localparam int MODE_LSB  = 8;
   localparam int MODE_W    = 3;
   localparam int STAT_BIT  = 12;
   localparam int POL_BIT   = 13;
   localparam int RACC_BIT  = 14;
   localparam int TRIG_BIT  = 15;
   localparam int MASK_BIT  = 16;
   localparam int TMODE_BIT = 17;

   // ==========================================================
   // delivery types
   localparam logic [2:0] MODE_FIXED = 3'h0;
   localparam logic [2:0] MODE_SMI   = 3'h2;
   localparam logic [2:0] MODE_NMI   = 3'h4;
   localparam logic [2:0] MODE_INIT  = 3'h5;
   localparam logic [2:0] MODE_EXT   = 3'h7;

   localparam logic [7:0]  VEC_MIN_LEGAL = 8'h10;
   localparam logic [31:0] ENTRY_RESET   = 32'h0001_0000;

   // ==========================================================
   // writable bits per entry kind; all else reads zero except the status and acceptance bits
   localparam logic [31:0] WMASK_TIMER = 32'h0003_00ff;
   localparam logic [31:0] WMASK_DELIV = 32'h0001_07ff;
   localparam logic [31:0] WMASK_PIN   = 32'h0001_a7ff;
   localparam logic [31:0] WMASK_ERROR = 32'h0001_00ff;

   function automatic logic [31:0] wmask_of(input logic [2:0] idx);
      case (idx)
         IDX_TIMER: wmask_of = WMASK_TIMER;
         IDX_PIN0,
         IDX_PIN1:  wmask_of = WMASK_PIN;
         IDX_ERROR: wmask_of = WMASK_ERROR;
         default:   wmask_of = WMASK_DELIV;
      endcase
   endfunction : wmask_of
endpackage : lvt_pkg

// ---- test/lvt_accept_model.sv ----
`timescale 1ns/1ps
module lvt_accept_model (
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_irq_valid,
   input  wire logic [2:0]  i_irq_type,
   input  wire logic [7:0]  i_irq_vector,
   input  wire logic [2:0]  i_irq_src,
   input  wire logic        i_intack_route,
   input  wire logic [7:0]  i_delay,
   output logic             o_irq_accept,
   output int               o_acc_cnt,
   output logic      [14:0] o_last
);
   // ==========================================================
   // core side: accepts an offer after i_delay falling edges
   logic [7:0] wait_r;

   // accept stands for exactly one rising edge, then drops with the offer
   always @(negedge i_clk) begin
      if (i_sys_rst || o_irq_accept || !i_irq_valid) begin
         o_irq_accept <= 1'b0;
         wait_r       <= 8'h0;
      end else if (wait_r >= i_delay) begin
         o_irq_accept <= 1'b1;
      end else begin
         wait_r <= wait_r + 8'h1;
      end
   end

   // a slow answer keeps the offer standing, so pending status can be seen
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_acc_cnt <= 0;
         o_last    <= 15'h0;
      end else if (o_irq_accept && i_irq_valid) begin
         o_acc_cnt <= o_acc_cnt + 1;
         // route is kept so the single external acknowledge path can be checked
         o_last    <= {i_intack_route, i_irq_type, i_irq_vector, i_irq_src};
      end
   end
endmodule : lvt_accept_model

// ---- test/lvt_core_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end

module lvt_core_test;
   // ==========================================================
   // signals
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [31:0] addr = 32'h0, wdata = 32'h0, rdata;
   logic [3:0]  evt = 4'h0;
   logic        pin0 = 1'b0, pin1 = 1'b0, no_io = 1'b0, end_of_interrupt_cmd = 1'b0, eclr = 1'b0;
   logic [7:0]  eoi_vec = 8'h0, delay = 8'h0;
   logic        valid, route, accept, periodic, err;
   logic [2:0]  ty, src;
   logic [7:0]  vec;
   logic [14:0] last;
   int          acc_cnt, acc_seen = 0, error_cnt = 0, samples_checked = 0;

   localparam logic [31:0] ADR [7] = '{lvt_pkg::ADDR_CORR, lvt_pkg::ADDR_TIMER,
      lvt_pkg::ADDR_THERMAL, lvt_pkg::ADDR_PERF, lvt_pkg::ADDR_PIN0, lvt_pkg::ADDR_PIN1,
      lvt_pkg::ADDR_ERROR};
   localparam logic [31:0] MSK [7] = '{lvt_pkg::WMASK_DELIV, lvt_pkg::WMASK_TIMER,
      lvt_pkg::WMASK_DELIV, lvt_pkg::WMASK_DELIV, lvt_pkg::WMASK_PIN, lvt_pkg::WMASK_PIN,
      lvt_pkg::WMASK_ERROR};
   localparam logic [31:0] SADR [4] = '{lvt_pkg::ADDR_TIMER, lvt_pkg::ADDR_THERMAL,
      lvt_pkg::ADDR_PERF, lvt_pkg::ADDR_CORR};
   localparam logic [2:0]  SIDX [4] = '{lvt_pkg::IDX_TIMER, lvt_pkg::IDX_THERMAL,
      lvt_pkg::IDX_PERF, lvt_pkg::IDX_CORR};
   localparam logic [2:0]  MD [5] = '{lvt_pkg::MODE_FIXED, lvt_pkg::MODE_SMI,
      lvt_pkg::MODE_NMI, lvt_pkg::MODE_INIT, lvt_pkg::MODE_EXT};
   localparam logic [7:0]  WV [5] = '{8'h44, 8'h00, 8'h55, 8'h00, 8'h00};
   localparam logic [7:0]  EV [5] = '{8'h44, 8'h00, 8'h00, 8'h00, 8'h00};

   always #20 clk = ~clk;

   lvt_core DUT (
      .i_clk(clk), .i_sys_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_timer_evt(evt[0]),
      .i_thermal_evt(evt[1]), .i_perf_evt(evt[2]), .i_corr_err_evt(evt[3]),
      .i_local_irq_pin0(pin0), .i_local_irq_pin1(pin1), .i_no_io_ctrl(no_io),
      .o_irq_valid(valid), .o_irq_type(ty), .o_irq_vector(vec), .o_irq_src(src),
      .o_intack_route(route), .i_irq_accept(accept), .i_eoi(end_of_interrupt_cmd), .i_eoi_vector(eoi_vec),
      .o_timer_periodic(periodic), .o_err_recv_illegal(err), .i_err_clr(eclr));

   lvt_accept_model CORE (
      .i_clk(clk), .i_sys_rst(rst), .i_irq_valid(valid), .i_irq_type(ty),
      .i_irq_vector(vec), .i_irq_src(src), .i_intack_route(route), .i_delay(delay),
      .o_irq_accept(accept), .o_acc_cnt(acc_cnt), .o_last(last));

   // ==========================================================
   // access tasks
   task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
   endtask : reg_wr

   task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
      @(negedge clk);
      rd = 1'b1;
      addr = a;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      `CHK($sformatf("read %h", a), e, rdata)
   endtask : chk_rd

   task automatic pulse(input logic [3:0] m);
      @(negedge clk);
      evt = m;
      @(negedge clk);
      evt = 4'h0;
   endtask : pulse

   task automatic send_eoi(input logic [7:0] v);
      @(negedge clk);
      end_of_interrupt_cmd = 1'b1;
      eoi_vec = v;
      @(negedge clk);
      end_of_interrupt_cmd = 1'b0;
   endtask : send_eoi

   // bounded wait for one more acceptance, then compare what was offered
   task automatic expect_irq(input logic [14:0] e);
      int n;
      for (n = 0; n < 60 && acc_cnt == acc_seen; n++) @(negedge clk);
      `CHK("irq count", acc_seen + 1, acc_cnt)
      `CHK("irq route/type/vector/src", e, last)
      acc_seen = acc_cnt;
   endtask : expect_irq

   task automatic expect_none();
      repeat (20) @(negedge clk);
      `CHK("no irq", acc_seen, acc_cnt)
   endtask : expect_none

   task automatic end_of_test();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test

   // ==========================================================
   // watchdog: the sequence needs well under 10000 cycles
   initial begin
      #(40 * 20000);
      error_cnt++;
      end_of_test();
   end

   // ==========================================================
   // tests
   initial begin
      int i;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      for (i = 0; i < 7; i++) chk_rd(ADR[i], lvt_pkg::ENTRY_RESET);
      chk_rd(32'hfee0_0380, 32'h0);
      // all-ones keeps every entry masked, so no pin can fire here
      for (i = 0; i < 7; i++) begin
         reg_wr(ADR[i], 32'hffff_ffff);
         chk_rd(ADR[i], MSK[i]);
         reg_wr(ADR[i], 32'h0001_0010);
      end
      reg_wr(lvt_pkg::ADDR_TIMER, 32'h0003_0020);
      `CHK("periodic", 1'b1, periodic)
      for (i = 0; i < 4; i++) begin
         reg_wr(SADR[i], 32'h20 + i);
         pulse(4'(1 << i));
         expect_irq({1'b0, lvt_pkg::MODE_FIXED, 8'(32'h20 + i), SIDX[i]});
      end
      `CHK("one-shot", 1'b0, periodic)
      chk_rd(lvt_pkg::ADDR_PERF, 32'h0001_0022);
      reg_wr(lvt_pkg::ADDR_PERF, 32'h0000_0022);
      chk_rd(lvt_pkg::ADDR_PERF, 32'h0000_0022);
      pulse(4'h3);
      expect_irq({1'b0, lvt_pkg::MODE_FIXED, 8'h20, lvt_pkg::IDX_TIMER});
      expect_irq({1'b0, lvt_pkg::MODE_FIXED, 8'h21, lvt_pkg::IDX_THERMAL});
      delay = 8'd10;
      pulse(4'h1);
      chk_rd(lvt_pkg::ADDR_TIMER, 32'h0000_1020);
      expect_irq({1'b0, lvt_pkg::MODE_FIXED, 8'h20, lvt_pkg::IDX_TIMER});
      chk_rd(lvt_pkg::ADDR_TIMER, 32'h0000_0020);
      delay = 8'd0;
      for (i = 0; i < 5; i++) begin
         reg_wr(lvt_pkg::ADDR_THERMAL, {21'h0, MD[i], WV[i]});
         pulse(4'h2);
         expect_irq({MD[i] == lvt_pkg::MODE_EXT, MD[i], EV[i], SIDX[1]});
      end
      reg_wr(lvt_pkg::ADDR_THERMAL, 32'h0000_0144);
      pulse(4'h2);
      reg_wr(lvt_pkg::ADDR_THERMAL, 32'h0001_0044);
      pulse(4'h2);
      expect_none();
      reg_wr(lvt_pkg::ADDR_ERROR, 32'h0000_0070);
      reg_wr(lvt_pkg::ADDR_THERMAL, 32'h0001_000f);
      @(negedge clk);
      `CHK("illegal flag", 1'b1, err)
      expect_irq({1'b0, lvt_pkg::MODE_FIXED, 8'h70, lvt_pkg::IDX_ERROR});
      @(negedge clk);
      eclr = 1'b1;
      @(negedge clk);
      eclr = 1'b0;
      `CHK("flag cleared", 1'b0, err)
      reg_wr(lvt_pkg::ADDR_THERMAL, 32'h0000_000f);
      expect_irq({1'b0, lvt_pkg::MODE_FIXED, 8'h70, lvt_pkg::IDX_ERROR});
      pulse(4'h2);
      expect_none();
      `CHK("flag sticky", 1'b1, err)
      @(negedge clk);
      eclr = 1'b1;
      @(negedge clk);
      eclr = 1'b0;
      reg_wr(lvt_pkg::ADDR_THERMAL, 32'h0000_0010);
      @(negedge clk);
      `CHK("vector 16 legal", 1'b0, err)
      pulse(4'h2);
      expect_irq({1'b0, lvt_pkg::MODE_FIXED, 8'h10, lvt_pkg::IDX_THERMAL});
      // pin tests: pins go through a synchroniser, expect_irq waits for it
      reg_wr(lvt_pkg::ADDR_PIN0, 32'h0000_a060);
      expect_irq({1'b0, lvt_pkg::MODE_FIXED, 8'h60, lvt_pkg::IDX_PIN0});
      chk_rd(lvt_pkg::ADDR_PIN0, 32'h0000_e060);
      expect_none();
      @(negedge clk);
      pin0 = 1'b1;
      send_eoi(8'h60);
      chk_rd(lvt_pkg::ADDR_PIN0, 32'h0000_a060);
      expect_none();
      reg_wr(lvt_pkg::ADDR_PIN1, 32'h0000_0061);
      pin1 = 1'b1;
      expect_irq({1'b0, lvt_pkg::MODE_FIXED, 8'h61, lvt_pkg::IDX_PIN1});
      send_eoi(8'h61);
      expect_none();
      pin1 = 1'b0;
      no_io = 1'b1;
      repeat (5) @(negedge clk);
      pin1 = 1'b1;
      expect_irq({1'b0, lvt_pkg::MODE_FIXED, 8'h61, lvt_pkg::IDX_PIN1});
      chk_rd(lvt_pkg::ADDR_PIN1, 32'h0000_4061);
      send_eoi(8'h61);
      expect_irq({1'b0, lvt_pkg::MODE_FIXED, 8'h61, lvt_pkg::IDX_PIN1});
      pin1 = 1'b0;
      send_eoi(8'h61);
      no_io = 1'b0;
      reg_wr(lvt_pkg::ADDR_PIN1, 32'h0000_8400);
      pin1 = 1'b1;
      expect_irq({1'b0, lvt_pkg::MODE_NMI, 8'h00, lvt_pkg::IDX_PIN1});
      expect_none();
      pin1 = 1'b0;
      reg_wr(lvt_pkg::ADDR_PIN0, 32'h0000_2700);
      pin0 = 1'b0;
      expect_irq({1'b1, lvt_pkg::MODE_EXT, 8'h00, lvt_pkg::IDX_PIN0});
      expect_irq({1'b1, lvt_pkg::MODE_EXT, 8'h00, lvt_pkg::IDX_PIN0});
      end_of_test();
   end
endmodule : lvt_core_test
